/* File: src/art_lfo_sync.sv */
`timescale 1ns/1ps
module art_lfo_sync (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic lfo_in,
    art_tick_if.lfo_src tick
);
    logic lfo_meta;
    logic lfo_sync;
    logic lfo_prev;

    // ---------------------------------------------------------------
    // two-flop synchroniser and falling edge pulse
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lfo_meta <= 1'b0;
            lfo_sync <= 1'b0;
            lfo_prev <= 1'b0;
            tick.lfo_fall <= 1'b0;
        end else begin
            lfo_meta <= lfo_in;
            lfo_sync <= lfo_meta;
            lfo_prev <= lfo_sync;
            tick.lfo_fall <= lfo_prev && !lfo_sync;
        end
    end
endmodule

/* File: src/art_pkg.sv */
package art_pkg;

// Operation
// - high byte rolling 0xFF to 0x00 sets high_overflow_flag; in 16-bit mode on 0xFFFF wrap
// - with timer interrupt enabled, a set high_overflow_flag requests an interrupt
// - low byte rolling 0xFF to 0x00 sets low_overflow_flag in every mode
// - hardware never clears either overflow flag; software clears them by writes
// - low_irq_enable plus timer interrupt enable makes low overflows request interrupts
// - lfo_capture_enable plus interrupt enable requests interrupt on each oscillator falling edge
// - capture mode copies high:low count into reload high:low on oscillator falling edge
// - split_mode_select bit 3: 0 one 16-bit counter, 1 two 8-bit counters
// - run_control enables counting; in split mode it gates only the high byte
// - control bit 1 reads zero and ignores writes
// - external_clock_select: 0 system_clock/12, 1 synchronised external oscillator/8
// - in split mode per-byte clock selects pick system_clock or that selected clock
// - two 8-bit read/write reload registers hold reload low and high bytes
// - read/write low count register: low byte in 16-bit mode, low counter in split
// - control register is bit-addressable as well as byte-writable
// - 16-bit wrap from 0xFFFF loads the reload pair into the counter
// - in split mode each byte reloads from its own reload register on overflow
// - byte clock select 1 counts on system_clock, 0 uses the selected slow clock
// - capture mode falling edge also sets high_overflow_flag

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
localparam logic [7:0] ART_ADDR_CONTROL = 8'hc8;
localparam logic [7:0] ART_ADDR_RELOAD_LOW = 8'hca;
localparam logic [7:0] ART_ADDR_RELOAD_HIGH = 8'hcb;
localparam logic [7:0] ART_ADDR_COUNT_LOW = 8'hcc;
localparam logic [7:0] ART_ADDR_COUNT_HIGH = 8'hcd;

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
localparam logic [2:0] ART_BIT_HIGH_FLAG = 3'h7;
localparam logic [2:0] ART_BIT_LOW_FLAG = 3'h6;
localparam logic [2:0] ART_BIT_LOW_IRQ_EN = 3'h5;
localparam logic [2:0] ART_BIT_CAPTURE_EN = 3'h4;
localparam logic [2:0] ART_BIT_SPLIT = 3'h3;
localparam logic [2:0] ART_BIT_RUN = 3'h2;
localparam logic [2:0] ART_BIT_UNUSED = 3'h1;
localparam logic [2:0] ART_BIT_XCLK = 3'h0;
localparam logic [7:0] ART_CONTROL_WMASK = 8'hfd;
localparam logic [7:0] ART_RESET_VALUE = 8'h00;
localparam logic [7:0] ART_BYTE_MAX = 8'hff;

// ---------------------------------------------------------------
// clock dividers
// ---------------------------------------------------------------
localparam int ART_DIV_SYS = 12;
localparam int ART_DIV_EXT = 8;
localparam logic [3:0] ART_DIV_SYS_LAST = 4'(ART_DIV_SYS - 1);
localparam logic [2:0] ART_DIV_EXT_LAST = 3'(ART_DIV_EXT - 1);

endpackage

/* File: src/art_prescale.sv */
`timescale 1ns/1ps
module art_prescale (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ext_osc_in,
    art_tick_if.tick_src tick
);
    logic [3:0] sys_div;
    logic [2:0] ext_div;
    logic ext_meta;
    logic ext_sync;
    logic ext_prev;

    // ---------------------------------------------------------------
    // system clock divided by 12
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sys_div <= 4'h0;
            tick.div_sys_tick <= 1'b0;
        end else begin
            tick.div_sys_tick <= (sys_div == art_pkg::ART_DIV_SYS_LAST);
            sys_div <= (sys_div == art_pkg::ART_DIV_SYS_LAST) ? 4'h0 : sys_div + 4'h1;
        end
    end

    // ---------------------------------------------------------------
    // external oscillator synchroniser and divide by 8
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_osc_in;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ext_div <= 3'h0;
            tick.div_ext_tick <= 1'b0;
        end else begin
            tick.div_ext_tick <= 1'b0;
            if (ext_sync && !ext_prev) begin
                ext_div <= ext_div + 3'h1;
                tick.div_ext_tick <= (ext_div == art_pkg::ART_DIV_EXT_LAST);
            end
        end
    end
endmodule

/* File: src/art_tick_if.sv */
`timescale 1ns/1ps
interface art_tick_if;
    logic div_sys_tick;
    logic div_ext_tick;
    logic lfo_fall;
    modport tick_src (output div_sys_tick, output div_ext_tick);
    modport lfo_src (output lfo_fall);
    modport dst (input div_sys_tick, input div_ext_tick, input lfo_fall);
endinterface

/* File: src/art_timer.sv */
`timescale 1ns/1ps
module art_timer (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic sfr_bit_wr,
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_value,
    input wire logic timer_irq_enable,
    input wire logic high_byte_clock_select,
    input wire logic low_byte_clock_select,
    input wire logic ext_osc_in,
    input wire logic lfo_in,
    output logic [7:0] sfr_rdata,
    output logic timer_irq
);

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic art_at_max(input logic [7:0] value);
        art_at_max = (value == art_pkg::ART_BYTE_MAX);
    endfunction

    function automatic logic art_hit(input logic strobe, input logic [7:0] addr,
                                     input logic [7:0] target);
        art_hit = strobe && (addr == target);
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [7:0] control;
    logic [7:0] reload_low_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] count_low_byte;
    logic [7:0] count_high_byte;
    logic [7:0] next_control;
    logic [7:0] next_count_low;
    logic [7:0] next_count_high;
    logic low_overflow;
    logic high_overflow;

    logic high_overflow_flag;
    logic low_overflow_flag;
    logic low_irq_enable;
    logic lfo_capture_enable;
    logic split_mode_select;
    logic run_control;
    logic external_clock_select;

    logic slow_tick;
    logic low_tick;
    logic high_tick;
    logic capture_event;
    logic wr_control;
    logic wr_reload_low;
    logic wr_reload_high;
    logic wr_count_low;
    logic wr_count_high;
    logic bit_wr_control;
    logic [2:0] bit_index;

    art_tick_if ticks ();

    // ---------------------------------------------------------------
    // clock sources
    // ---------------------------------------------------------------
    art_prescale u_prescale (
        .sys_clk(sys_clk),
        .reset(reset),
        .ext_osc_in(ext_osc_in),
        .tick(ticks.tick_src)
    );

    art_lfo_sync u_lfo_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .lfo_in(lfo_in),
        .tick(ticks.lfo_src)
    );

    // ---------------------------------------------------------------
    // control fields
    // ---------------------------------------------------------------
    assign high_overflow_flag = control[art_pkg::ART_BIT_HIGH_FLAG];
    assign low_overflow_flag = control[art_pkg::ART_BIT_LOW_FLAG];
    assign low_irq_enable = control[art_pkg::ART_BIT_LOW_IRQ_EN];
    assign lfo_capture_enable = control[art_pkg::ART_BIT_CAPTURE_EN];
    assign split_mode_select = control[art_pkg::ART_BIT_SPLIT];
    assign run_control = control[art_pkg::ART_BIT_RUN];
    assign external_clock_select = control[art_pkg::ART_BIT_XCLK];

    // ---------------------------------------------------------------
    // address decode
    // ---------------------------------------------------------------
    assign wr_control = art_hit(sfr_wr, sfr_addr, art_pkg::ART_ADDR_CONTROL);
    assign wr_reload_low = art_hit(sfr_wr, sfr_addr, art_pkg::ART_ADDR_RELOAD_LOW);
    assign wr_reload_high = art_hit(sfr_wr, sfr_addr, art_pkg::ART_ADDR_RELOAD_HIGH);
    assign wr_count_low = art_hit(sfr_wr, sfr_addr, art_pkg::ART_ADDR_COUNT_LOW);
    assign wr_count_high = art_hit(sfr_wr, sfr_addr, art_pkg::ART_ADDR_COUNT_HIGH);

    // bit addresses of the control register share its upper five bits
    assign bit_wr_control = sfr_bit_wr &&
        (sfr_bit_addr[7:3] == art_pkg::ART_ADDR_CONTROL[7:3]);
    assign bit_index = sfr_bit_addr[2:0];

    // ---------------------------------------------------------------
    // per-byte clock selection
    // ---------------------------------------------------------------
    assign slow_tick = external_clock_select ? ticks.div_ext_tick
                                             : ticks.div_sys_tick;
    assign low_tick = low_byte_clock_select ? 1'b1 : slow_tick;
    assign high_tick = high_byte_clock_select ? 1'b1 : slow_tick;

    assign capture_event = lfo_capture_enable && ticks.lfo_fall;

    // ---------------------------------------------------------------
    // counter next value
    // ---------------------------------------------------------------
    always_comb begin
        next_count_low = count_low_byte;
        next_count_high = count_high_byte;
        low_overflow = 1'b0;
        high_overflow = 1'b0;
        if (!split_mode_select) begin
            // one 16-bit counter clocked by the low byte select
            if (run_control && low_tick) begin
                if (art_at_max(count_low_byte)) begin
                    low_overflow = 1'b1;
                    if (art_at_max(count_high_byte)) begin
                        high_overflow = 1'b1;
                        next_count_low = reload_low_byte;
                        next_count_high = reload_high_byte;
                    end else begin
                        next_count_low = 8'h00;
                        next_count_high = count_high_byte + 8'h01;
                    end
                end else begin
                    next_count_low = count_low_byte + 8'h01;
                end
            end
        end else begin
            // low byte always runs in split mode
            if (low_tick) begin
                if (art_at_max(count_low_byte)) begin
                    low_overflow = 1'b1;
                    next_count_low = reload_low_byte;
                end else begin
                    next_count_low = count_low_byte + 8'h01;
                end
            end
            if (run_control && high_tick) begin
                if (art_at_max(count_high_byte)) begin
                    high_overflow = 1'b1;
                    next_count_high = reload_high_byte;
                end else begin
                    next_count_high = count_high_byte + 8'h01;
                end
            end
        end
        // a software write replaces the stepped value
        if (wr_count_low) begin
            next_count_low = sfr_wdata;
        end
        if (wr_count_high) begin
            next_count_high = sfr_wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count_low_byte <= art_pkg::ART_RESET_VALUE;
            count_high_byte <= art_pkg::ART_RESET_VALUE;
        end else begin
            count_low_byte <= next_count_low;
            count_high_byte <= next_count_high;
        end
    end

    // ---------------------------------------------------------------
    // control register
    // ---------------------------------------------------------------
    always_comb begin
        next_control = control;
        if (wr_control) begin
            next_control = sfr_wdata & art_pkg::ART_CONTROL_WMASK;
        end
        if (bit_wr_control && (bit_index != art_pkg::ART_BIT_UNUSED)) begin
            next_control[bit_index] = sfr_bit_value;
        end
        // hardware sets win over a clear in the same cycle; never cleared here
        if (high_overflow || capture_event) begin
            next_control[art_pkg::ART_BIT_HIGH_FLAG] = 1'b1;
        end
        if (low_overflow) begin
            next_control[art_pkg::ART_BIT_LOW_FLAG] = 1'b1;
        end
        next_control[art_pkg::ART_BIT_UNUSED] = 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            control <= art_pkg::ART_RESET_VALUE;
        end else begin
            control <= next_control;
        end
    end

    // ---------------------------------------------------------------
    // reload registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reload_low_byte <= art_pkg::ART_RESET_VALUE;
            reload_high_byte <= art_pkg::ART_RESET_VALUE;
        end else if (capture_event) begin
            // capture takes the count as it stands before this edge
            reload_low_byte <= count_low_byte;
            reload_high_byte <= count_high_byte;
        end else begin
            if (wr_reload_low) begin
                reload_low_byte <= sfr_wdata;
            end
            if (wr_reload_high) begin
                reload_high_byte <= sfr_wdata;
            end
        end
    end

    // ---------------------------------------------------------------
    // interrupt request
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            timer_irq <= 1'b0;
        end else begin
            // capture sets the high flag, so it requests through the same term
            timer_irq <= timer_irq_enable &&
                (high_overflow_flag || (low_irq_enable && low_overflow_flag));
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_rd) begin
            unique case (sfr_addr)
                art_pkg::ART_ADDR_CONTROL: begin
                    sfr_rdata <= control;
                end
                art_pkg::ART_ADDR_RELOAD_LOW: begin
                    sfr_rdata <= reload_low_byte;
                end
                art_pkg::ART_ADDR_RELOAD_HIGH: begin
                    sfr_rdata <= reload_high_byte;
                end
                art_pkg::ART_ADDR_COUNT_LOW: begin
                    sfr_rdata <= count_low_byte;
                end
                art_pkg::ART_ADDR_COUNT_HIGH: begin
                    sfr_rdata <= count_high_byte;
                end
                default: begin
                    sfr_rdata <= 8'h00;
                end
            endcase
        end
    end
endmodule

/* File: testbench/art_host.sv */
`timescale 1ns/1ps
// processor-side register bus driver; every task starts and ends at a falling edge
module art_host (
    input wire logic sys_clk,
    input wire logic [7:0] sfr_rdata,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic [7:0] sfr_wdata,
    output logic sfr_rd,
    output logic sfr_bit_wr,
    output logic [7:0] sfr_bit_addr,
    output logic sfr_bit_value
);
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_wdata = 8'h00;
        sfr_rd = 1'b0;
        sfr_bit_wr = 1'b0;
        sfr_bit_addr = 8'h00;
        sfr_bit_value = 1'b0;
    end
    // strobes stay up between back-to-back transfers, so each changes once per step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        sfr_rd = 1'b0;
        sfr_bit_wr = 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        sfr_wr = 1'b0;
        sfr_rd = 1'b1;
        sfr_bit_wr = 1'b0;
        @(negedge sys_clk);
        d = sfr_rdata;
    endtask
    task automatic bwr(input logic [7:0] a, input logic v);
        sfr_bit_addr = a;
        sfr_bit_value = v;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_bit_wr = 1'b1;
        @(negedge sys_clk);
    endtask
    task automatic idle();
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_bit_wr = 1'b0;
        @(negedge sys_clk);
    endtask
endmodule

/* File: testbench/art_timer_asserts.sv */
`timescale 1ns/1ps
module art_timer_asserts (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_rd,
    input wire logic sfr_bit_wr,
    input wire logic [7:0] sfr_bit_addr,
    input wire logic sfr_bit_value,
    input wire logic timer_irq_enable,
    input wire logic [7:0] sfr_rdata,
    input wire logic timer_irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_rst; $fell(reset) |-> sfr_rdata == 8'h00 && !timer_irq; endproperty
    a_rst: assert property (p_rst) else $error("outputs not zero after reset");
    property p_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_bit1; sfr_rd && sfr_addr == 8'hc8 |=> !sfr_rdata[1]; endproperty
    a_bit1: assert property (p_bit1) else $error("unused control bit reads one");
    property p_irq_off; !timer_irq_enable |=> !timer_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    property p_irq_cause; $rose(timer_irq) |-> $past(timer_irq_enable); endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq rose unenabled");
    property p_ctrl_wr;
        sfr_wr && sfr_addr == 8'hc8 ##1 sfr_rd && sfr_addr == 8'hc8
            |=> (sfr_rdata & 8'h3d) == ($past(sfr_wdata, 2) & 8'h3d);
    endproperty
    a_ctrl_wr: assert property (p_ctrl_wr) else $error("control readback wrong");
    property p_bit_wr;
        sfr_bit_wr && sfr_bit_addr == 8'hcb ##1 sfr_rd && sfr_addr == 8'hc8
            |=> sfr_rdata[3] == $past(sfr_bit_value, 2);
    endproperty
    a_bit_wr: assert property (p_bit_wr) else $error("bit write lost");
    property p_reload;
        sfr_wr && sfr_addr == 8'hca ##1 sfr_rd && sfr_addr == 8'hca
            |=> sfr_rdata == $past(sfr_wdata, 2);
    endproperty
    a_reload: assert property (p_reload) else $error("reload readback wrong");
    c_irq: cover property ($rose(timer_irq));
    c_bit: cover property (sfr_bit_wr && sfr_bit_value);
    c_high: cover property (sfr_rd && sfr_addr == 8'hcd);
endmodule
bind art_timer art_timer_asserts u_chk (.sys_clk(sys_clk), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr), .sfr_bit_value(sfr_bit_value),
    .timer_irq_enable(timer_irq_enable), .sfr_rdata(sfr_rdata), .timer_irq(timer_irq));

/* File: testbench/auto_reload_timer_two_tb.sv */
`timescale 1ns/1ps
module auto_reload_timer_two_tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic timer_irq_enable = 1'b0;
    logic hi_sel = 1'b0;
    logic lo_sel = 1'b0;
    logic ext_osc_in = 1'b0;
    logic lfo_in = 1'b1;
    logic [7:0] sfr_addr, sfr_wdata, sfr_bit_addr, sfr_rdata, d, rl, rh;
    logic sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_value, timer_irq;
    logic [7:0] regs [6] = '{8'hc8, 8'hc9, 8'hca, 8'hcb, 8'hcc, 8'hcd};
    int n_fail = 0;
    int num_checks = 0;
    int seed;
    initial forever #20 sys_clk = ~sys_clk;
    art_host h (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_addr(sfr_bit_addr), .sfr_bit_value(sfr_bit_value));
    art_timer dut (.sys_clk(sys_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr),
        .sfr_bit_addr(sfr_bit_addr), .sfr_bit_value(sfr_bit_value),
        .timer_irq_enable(timer_irq_enable), .high_byte_clock_select(hi_sel),
        .low_byte_clock_select(lo_sel), .ext_osc_in(ext_osc_in), .lfo_in(lfo_in),
        .sfr_rdata(sfr_rdata), .timer_irq(timer_irq));
    function automatic logic [7:0] ctrl_exp(input logic [7:0] w);
        return w & 8'hfd;
    endfunction
    function automatic logic [7:0] ticks_exp(input int cyc, input int per);
        return 8'(cyc / per);
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: read %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_irq(input logic lvl, input int lim);
        for (int i = 0; i < lim && timer_irq !== lvl; i++) @(negedge sys_clk);
        num_checks++;
        if (timer_irq !== lvl) begin
            n_fail++;
            $display("Error %0t: irq did not reach %b", $time, lvl);
            summarize();
        end
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        $display("Error %0t: run too long", $time);
        summarize();
    end
    initial begin
        seed = $urandom(32'h8789cf5d);
        repeat (5) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        foreach (regs[i]) begin
            h.rd(regs[i], d);
            chk(d, 8'h00);
        end
        // ---------------------------------------------------------------
        // random register traffic
        // ---------------------------------------------------------------
        repeat (4) begin
            d = 8'($urandom) & 8'heb;
            h.wr(8'hc8, d);
            h.rd(8'hc8, rl);
            chk(rl, ctrl_exp(d));
            rl = 8'($urandom);
            h.wr(8'hca, rl);
            h.rd(8'hca, d);
            chk(d, rl);
        end
        h.wr(8'hc8, 8'h00);
        for (int i = 0; i < 8; i++) begin
            h.bwr(8'hc8 + 8'(i), 1'b1);
            h.rd(8'hc8, d);
            chk(d, ctrl_exp(8'h01 << i));
            h.bwr(8'hc8 + 8'(i), 1'b0);
        end
        // ---------------------------------------------------------------
        // 16-bit wrap, flags and irq
        // ---------------------------------------------------------------
        rl = 8'h40 | (8'($urandom) & 8'h3f);
        rh = 8'($urandom);
        h.wr(8'hcb, rh);
        h.wr(8'hca, rl);
        h.wr(8'hcc, 8'hfe);
        h.wr(8'hcd, 8'hff);
        lo_sel = 1'b1;
        timer_irq_enable = 1'b1;
        h.wr(8'hc8, 8'h04);
        h.idle();
        wait_irq(1'b1, 8);
        h.wr(8'hc8, 8'hc0);
        h.rd(8'hcd, d);
        chk(d, rh);
        h.rd(8'hc8, d);
        chk(d, 8'hc0);
        h.idle();
        repeat (20) @(negedge sys_clk);
        h.rd(8'hc8, d);
        chk(d, 8'hc0);
        h.wr(8'hc8, 8'h00);
        h.idle();
        wait_irq(1'b0, 3);
        // ---------------------------------------------------------------
        // split mode
        // ---------------------------------------------------------------
        hi_sel = 1'b1;
        h.wr(8'hcd, 8'hff);
        h.wr(8'hcc, 8'hfd);
        h.wr(8'hc8, 8'h28);
        h.idle();
        wait_irq(1'b1, 10);
        h.rd(8'hcd, d);
        chk(d, 8'hff);
        h.rd(8'hc8, d);
        chk(d, 8'h68);
        h.rd(8'hcc, d);
        chk(8'(8'(d - rl) < 8'h10), 8'h01);
        h.wr(8'hc8, 8'h0c);
        // high byte wraps on the edge after run is set, the read follows it
        h.idle();
        h.rd(8'hc8, d);
        chk(d, 8'h8c);
        h.rd(8'hcd, d);
        chk(d, rh + 8'h01);
        // ---------------------------------------------------------------
        // slow clocks
        // ---------------------------------------------------------------
        lo_sel = 1'b0;
        h.wr(8'hc8, 8'h00);
        h.wr(8'hcc, 8'h00);
        h.wr(8'hcd, 8'h00);
        h.wr(8'hc8, 8'h04);
        h.idle();
        repeat (119) @(negedge sys_clk);
        h.wr(8'hc8, 8'h00);
        h.rd(8'hcc, d);
        chk(8'(d + 8'h01 - ticks_exp(120, 12) <= 8'h02), 8'h01);
        h.wr(8'hcc, 8'h00);
        h.wr(8'hc8, 8'h05);
        h.idle();
        repeat (80) begin
            ext_osc_in = 1'b1;
            repeat (2) @(negedge sys_clk);
            ext_osc_in = 1'b0;
            repeat (2) @(negedge sys_clk);
        end
        repeat (8) @(negedge sys_clk);
        h.wr(8'hc8, 8'h01);
        h.rd(8'hcc, d);
        chk(d, ticks_exp(80, 8));
        // ---------------------------------------------------------------
        // oscillator capture
        // ---------------------------------------------------------------
        h.wr(8'hcd, 8'h12);
        h.wr(8'hcc, 8'h00);
        h.wr(8'hcb, 8'h00);
        h.wr(8'hca, 8'h00);
        lo_sel = 1'b1;
        h.wr(8'hc8, 8'h14);
        h.idle();
        lfo_in = 1'b0;
        wait_irq(1'b1, 10);
        h.bwr(8'hca, 1'b0);
        h.rd(8'hcb, d);
        chk(d, 8'h12);
        h.rd(8'hca, d);
        chk(8'(d != 8'h00 && d < 8'h10), 8'h01);
        h.rd(8'hc8, d);
        chk(d, 8'h90);
        lfo_in = 1'b1;
        h.idle();
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0;
        @(negedge sys_clk);
        h.rd(8'hcb, d);
        chk(d, 8'h00);
        h.idle();
        summarize();
    end
endmodule
